// ---- hdl/ppc_pin_ctrl.sv ----
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ns
`include "ppc_defines.svh"

// How it works
// - After power-on into user mode the reset pin is a port input; option bit makes reset.
// - Reset pin enable stays set until next power-on; clearing it is ignored.
// - Shared pin as reset: external low level starts an internal reset.
// - Reset pin enable set forces the pull-up on that pin.
// - Power-on into background mode defaults the shared pin to reset input.
// - Timer 2 capture mode routes the shared pin to the capture input.
// - Debug pin is mode select during reset, debug line right after.
// - Mode pin sampled at reset release; high selects run mode.
// - Debug pin enable sets on every reset; cleared before other pin functions work.
// - Debug pin enable set forces the pull-up on the debug pin while it is not driven.
// - Debug bit time is sixteen core_clk cycles.
// - After reset all non-output-only pins are undriven inputs, pull-ups off except on an enabled reset pin.
// - Output-only pin after reset: disabled, low drive, slew limiting on.
// - Pull-up forced off whenever the pin is driven as output.
// - Pull-up forced off whenever an analog function owns the pin.
// - Rising-edge keyboard or interrupt detection turns enabled pull into pull-down.
// - Slew bit acts only while the pin is an output.
// - Drive select bit set gives high drive, clear gives low drive.
// - Pin ownership by fixed priority, port lowest, analog, reset or mode select highest.
// - Two analog modules enabled on one pin both connect to it.
// - Pull, slew, drive bits work apart from port data and direction.
module ppc_pin_ctrl (
  // Clock and power-on reset
  input wire logic core_clk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pads
  input wire logic [5:0] pad_in,
  output ppc_pkg::ppc_pad_t pad,
  // Peripheral side
  input wire ppc_pkg::ppc_periph_t periph,
  output ppc_pkg::ppc_route_t route,
  // System
  output logic sys_rst_n,
  output logic bg_mode,
  output logic dbg_bit_tick
);
  import ppc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  ppc_rst_state_t state_r;
  ppc_rst_state_t state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic rst_pin_en_r;
  logic dbg_pin_en_r;
  logic bg_mode_r;
  logic [5:0] pullup_r;
  logic [5:0] slew_r;
  logic [5:0] drive_r;
  logic [3:0] bit_cnt_r;
  logic pready_r;
  logic pslverr_r;
  logic [31:0] prdata_r;
  logic sys_rst_n_r;
  logic dbg_bit_tick_r;
  ppc_pad_t pad_r;
  ppc_route_t route_r;

  ppc_owner_t own [6];
  logic [5:0] drv;
  logic [5:0] drv_val;
  logic [5:0] ana;
  logic [5:0] forced_pu;
  logic [5:0] rise;
  logic [5:0] pu_nxt;
  logic [5:0] pd_nxt;
  ppc_pad_t pad_nxt;
  ppc_route_t route_nxt;

  // Pull device from enable bit, forcing and overrides: {pulldown, pullup}
  function automatic logic [1:0] pull_of(input logic en_bit, input logic forced, input logic driven,
                                         input logic analog, input logic rising);
    logic en;
    en = (en_bit | forced) & ~driven & ~analog;
    pull_of = {en & rising & ~forced, en & ~(rising & ~forced)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Internal reset sequencer

  wire in_reset = (state_r != RS_RUN);
  wire hold_done = (cnt_r == `PPC_RST_HOLD_CYC - 4'h1);
  wire mode_sampled = in_reset & hold_done;
  wire ext_rst_req = (own[5] == OWN_RESET) & ~pad_in[5];
  wire bus_wr = psel & penable & pready_r & pwrite & ~in_reset;
  wire force_req = bus_wr & (paddr == `PPC_OFS_FORCE_RST) & pwdata[`PPC_BIT_FORCE_RST];

  // A reset pin held low keeps restarting the hold count
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    if (!in_reset)
    begin
      cnt_nxt = 4'h0;
      if (force_req)
        state_nxt = RS_FORCE;
      else if (ext_rst_req)
        state_nxt = RS_EXT;
    end
    else if (state_r == RS_EXT && ~pad_in[5])
      cnt_nxt = 4'h0;
    else if (hold_done)
    begin
      state_nxt = RS_RUN;
      cnt_nxt = 4'h0;
    end
    else
      cnt_nxt = cnt_r + 4'h1;
  end

  // Sequencer flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r <= RS_POR;
      cnt_r <= 4'h0;
      sys_rst_n_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sys_rst_n_r <= (state_nxt == RS_RUN);
    end
  end

  // Mode sampled at reset release; the reset pin can only reset into user mode
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      bg_mode_r <= 1'b0;
    else if (mode_sampled)
      bg_mode_r <= (state_r != RS_EXT) & ~pad_in[4];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Option bits

  // Only power-on clears the reset pin enable; software can only set it
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_pin_en_r <= 1'b0;
    else if (mode_sampled && state_r == RS_POR && ~pad_in[4])
      rst_pin_en_r <= 1'b1;
    else if (bus_wr && paddr == `PPC_OFS_SYS_OPT && pwdata[`PPC_BIT_RST_PIN_EN])
      rst_pin_en_r <= 1'b1;
  end

  // Debug pin enable comes back on with every reset of any kind
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      dbg_pin_en_r <= 1'b1;
    else if (in_reset)
      dbg_pin_en_r <= 1'b1;
    else if (bus_wr && paddr == `PPC_OFS_SYS_OPT)
      dbg_pin_en_r <= pwdata[`PPC_BIT_DBG_PIN_EN];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad control registers, bit n for pin n, apart from port data and direction

  wire wr_pullup = bus_wr & (paddr == `PPC_OFS_PULLUP);
  wire wr_slew = bus_wr & (paddr == `PPC_OFS_SLEW);
  wire wr_drive = bus_wr & (paddr == `PPC_OFS_DRIVE);

  // Any internal reset returns them to their defaults
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pullup_r <= `PPC_PULLUP_RST;
      slew_r <= `PPC_SLEW_RST;
      drive_r <= `PPC_DRIVE_RST;
    end
    else if (in_reset)
    begin
      pullup_r <= `PPC_PULLUP_RST;
      slew_r <= `PPC_SLEW_RST;
      drive_r <= `PPC_DRIVE_RST;
    end
    else
    begin
      if (wr_pullup)
        pullup_r <= pwdata[5:0];
      if (wr_slew)
        slew_r <= pwdata[5:0];
      if (wr_drive)
        drive_r <= pwdata[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin ownership by priority and what each owner does to the pad

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_low
      // Analog, then timer channel or clock, then keyboard, then port
      assign ana[gi] = periph.adc_en[gi] | periph.an2_en[gi];
      assign own[gi] = ana[gi] ? OWN_ANALOG :
                       (gi < 2 ? periph.tmr1_en[gi % 2] : periph.tclk_en[gi % 2]) ?
                       (gi < 2 ? OWN_TIMER : OWN_CLK) :
                       periph.kbi_en[gi] ? OWN_KBI : OWN_PORT;
      assign drv[gi] = (own[gi] == OWN_PORT && periph.port_dir[gi]) ||
                       (own[gi] == OWN_TIMER && periph.tmr1_oe[gi % 2]);
      assign drv_val[gi] = (own[gi] == OWN_TIMER) ? periph.tmr1_out[gi % 2] : periph.port_out[gi];
      assign forced_pu[gi] = 1'b0;
      assign rise[gi] = (own[gi] == OWN_KBI) & periph.kbi_rise[gi];
    end
  endgenerate

  // Output-only pin: mode select in reset, then debug, timer compare, port
  assign own[4] = in_reset ? OWN_MODE : dbg_pin_en_r ? OWN_DEBUG :
                  periph.tmr2_oe ? OWN_TIMER : OWN_PORT;
  assign drv[4] = (own[4] == OWN_PORT && periph.port_dir[4]) || own[4] == OWN_TIMER ||
                  (own[4] == OWN_DEBUG && periph.dbg_oe);
  assign drv_val[4] = (own[4] == OWN_DEBUG) ? periph.dbg_out :
                      (own[4] == OWN_TIMER) ? periph.tmr2_out : periph.port_out[4];
  assign forced_pu[4] = dbg_pin_en_r;
  assign rise[4] = 1'b0;
  assign ana[4] = 1'b0;

  // Input-only pin: reset, then interrupt, then timer capture, then port
  assign own[5] = rst_pin_en_r ? OWN_RESET : periph.irq_en ? OWN_IRQ :
                  periph.tmr2_cap_mode ? OWN_TIMER : OWN_PORT;
  assign drv[5] = 1'b0;
  assign drv_val[5] = 1'b0;
  assign forced_pu[5] = rst_pin_en_r;
  assign rise[5] = (own[5] == OWN_IRQ) & periph.irq_rise;
  assign ana[5] = 1'b0;

  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_pull
      assign {pd_nxt[gi], pu_nxt[gi]} = pull_of(pullup_r[gi], forced_pu[gi], drv[gi], ana[gi], rise[gi]);
    end
  endgenerate

  // Slew and drive only mean anything on a driven pad
  assign pad_nxt.out = drv_val & drv;
  assign pad_nxt.oe_n = ~drv;
  assign pad_nxt.pu = pu_nxt;
  assign pad_nxt.pd = pd_nxt;
  assign pad_nxt.slew = slew_r & drv;
  assign pad_nxt.drive = drive_r & drv;
  assign pad_nxt.analog = ana;

  // Both analog modules see the pin at once, no arbitration between them
  assign route_nxt.port_in = pad_in;
  assign route_nxt.kbi_in = pad_in[3:0];
  assign route_nxt.tmr1_in = pad_in[1:0];
  assign route_nxt.tclk_in = pad_in[3:2];
  assign route_nxt.tmr2_cap_in = (own[5] == OWN_TIMER) & pad_in[5];
  assign route_nxt.irq_in = (own[5] == OWN_IRQ) & pad_in[5];
  assign route_nxt.dbg_in = (own[4] == OWN_DEBUG) ? pad_in[4] : 1'b1;
  assign route_nxt.adc_conn = periph.adc_en & ana[3:0];
  assign route_nxt.an2_conn = periph.an2_en & ana[3:0];

  // Registered pad and route outputs
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pad_r <= '{out: 6'h00, oe_n: 6'h3f, pu: 6'h00, pd: 6'h00, slew: 6'h00, drive: 6'h00, analog: 6'h00};
      route_r <= '0;
    end
    else
    begin
      pad_r <= pad_nxt;
      route_r <= route_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Debug bit-time base: one tick per bit while the debug line owns the pin

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bit_cnt_r <= 4'h0;
      dbg_bit_tick_r <= 1'b0;
    end
    else if (own[4] != OWN_DEBUG)
    begin
      bit_cnt_r <= 4'h0;
      dbg_bit_tick_r <= 1'b0;
    end
    else
    begin
      bit_cnt_r <= bit_cnt_r + 4'h1;
      dbg_bit_tick_r <= ({1'b0, bit_cnt_r} == `PPC_DBG_BIT_CYC - 5'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave; answer is prepared in the setup cycle so every output is a flop

  wire setup = psel & ~penable;
  wire hit_sys = (paddr == `PPC_OFS_SYS_OPT);
  wire hit_pu = (paddr == `PPC_OFS_PULLUP);
  wire hit_sl = (paddr == `PPC_OFS_SLEW);
  wire hit_dr = (paddr == `PPC_OFS_DRIVE);
  wire hit_st = (paddr == `PPC_OFS_STATUS);
  wire hit_fr = (paddr == `PPC_OFS_FORCE_RST);
  wire mapped = hit_sys | hit_pu | hit_sl | hit_dr | hit_st | hit_fr;
  wire [31:0] status_word = ({31'h0, bg_mode_r} << `PPC_BIT_BG_MODE) |
                            ({31'h0, in_reset} << `PPC_BIT_IN_RESET) |
                            ({26'h0, ~pad_r.oe_n} << `PPC_LSB_DRIVEN) |
                            ({26'h0, pad_r.pu | pad_r.pd} << `PPC_LSB_PULLED);
  wire [31:0] rd_word = hit_sys ? ({31'h0, rst_pin_en_r} << `PPC_BIT_RST_PIN_EN) |
                                  ({31'h0, dbg_pin_en_r} << `PPC_BIT_DBG_PIN_EN) :
                        hit_pu ? {26'h0, pullup_r} :
                        hit_sl ? {26'h0, slew_r} :
                        hit_dr ? {26'h0, drive_r} :
                        hit_st ? status_word : 32'h0;

  // Ready stands for exactly the access cycle that follows a setup
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup & ~mapped;
      prdata_r <= (setup && !pwrite) ? rd_word : 32'h0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign pad = pad_r;
  assign route = route_r;
  assign sys_rst_n = sys_rst_n_r;
  assign bg_mode = bg_mode_r;
  assign dbg_bit_tick = dbg_bit_tick_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_rst_pin_sticky: assert property (rst_pin_en_r |=> rst_pin_en_r)
    else $error("reset pin enable was cleared");
  a_rst_pin_pullup: assert property (rst_pin_en_r |=> pad.pu[4+1] && !pad.pd[5])
    else $error("reset pin lacks pull-up");
  a_ext_reset_start: assert property (!in_reset && !force_req && ext_rst_req |=> !sys_rst_n [*8])
    else $error("reset pin low did not reset");
  // The mode flag holds its old value through the hold, so it is checked only at release
  a_ext_user_mode: assert property (state_r == RS_EXT && hold_done |=> !bg_mode)
    else $error("reset pin entered background mode");
  a_por_bg_default: assert property (state_r == RS_POR && hold_done && !pad_in[4]
                                     |=> bg_mode && rst_pin_en_r && sys_rst_n)
    else $error("background power-on did not default to reset pin");
  a_mode_high_run: assert property (in_reset && hold_done && pad_in[4] |=> !bg_mode)
    else $error("high mode pin did not select run mode");
  a_dbg_pin_set: assert property (in_reset |=> dbg_pin_en_r)
    else $error("debug pin enable not set by reset");
  a_dbg_pullup: assert property (dbg_pin_en_r && !drv[4] |=> pad.pu[4])
    else $error("debug pin lacks pull-up");
  a_pull_off_drv: assert property ((~pad.oe_n & (pad.pu | pad.pd)) == 6'h00)
    else $error("pull active on a driven pin");
  a_pull_off_ana: assert property ((pad.analog & (pad.pu | pad.pd)) == 6'h00)
    else $error("pull active on an analog pin");
  a_slew_input: assert property (((pad.slew | pad.drive) & pad.oe_n) == 6'h00)
    else $error("slew or drive on an input pin");
  a_capture_route: assert property (own[5] == OWN_TIMER |=> route.tmr2_cap_in == $past(pad_in[5]))
    else $error("capture input not routed");
  a_bit_spacing: assert property (dbg_bit_tick |=> !dbg_bit_tick [*8] ##1 !dbg_bit_tick [*7])
    else $error("debug bit ticks too close");

  c_por_background: cover property (state_r == RS_POR && hold_done && !pad_in[4]);
  c_force_reset: cover property (force_req ##[1:20] sys_rst_n);
  c_ext_reset: cover property (ext_rst_req && !in_reset);
  c_kbi_pulldown: cover property (|pad.pd[3:0]);

endmodule

// ---- shared/ppc_defines.svh ----
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

// Register byte offsets on the APB side
`define PPC_OFS_SYS_OPT 8'h00
`define PPC_OFS_PULLUP 8'h04
`define PPC_OFS_SLEW 8'h08
`define PPC_OFS_DRIVE 8'h0c
`define PPC_OFS_STATUS 8'h10
`define PPC_OFS_FORCE_RST 8'h14

// Field positions
`define PPC_BIT_RST_PIN_EN 0
`define PPC_BIT_DBG_PIN_EN 1
`define PPC_BIT_FORCE_RST 0
`define PPC_BIT_BG_MODE 0
`define PPC_BIT_IN_RESET 1
`define PPC_LSB_DRIVEN 8
`define PPC_LSB_PULLED 16

// Reset values of the pad control registers
`define PPC_PULLUP_RST 6'h00
`define PPC_SLEW_RST 6'h10
`define PPC_DRIVE_RST 6'h00

// Timing counts in core_clk cycles
`define PPC_RST_HOLD_CYC 4'h8
`define PPC_DBG_BIT_CYC 5'h10

`endif

// ---- shared/ppc_pkg.sv ----
package ppc_pkg;

  // Who owns a shared pin
  typedef enum logic [3:0] {
    OWN_PORT, OWN_KBI, OWN_TIMER, OWN_CLK, OWN_DEBUG, OWN_MODE, OWN_IRQ, OWN_ANALOG, OWN_RESET
  } ppc_owner_t;

  // Internal reset sequencer
  typedef enum logic [1:0] {RS_POR, RS_FORCE, RS_EXT, RS_RUN} ppc_rst_state_t;

  // Requests from the port logic and the shared peripherals
  typedef struct packed {
    logic [5:0] port_dir;
    logic [5:0] port_out;
    logic [3:0] kbi_en;
    logic [3:0] kbi_rise;
    logic [1:0] tmr1_en;
    logic [1:0] tmr1_oe;
    logic [1:0] tmr1_out;
    logic [1:0] tclk_en;
    logic tmr2_cap_mode;
    logic tmr2_oe;
    logic tmr2_out;
    logic irq_en;
    logic irq_rise;
    logic [3:0] adc_en;
    logic [3:0] an2_en;
    logic dbg_oe;
    logic dbg_out;
  } ppc_periph_t;

  // Pad controls; oe_n low while the pad is driven
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe_n;
    logic [5:0] pu;
    logic [5:0] pd;
    logic [5:0] slew;
    logic [5:0] drive;
    logic [5:0] analog;
  } ppc_pad_t;

  // Pin levels routed back to the functions; capture, interrupt and debug inputs only from a pin they own
  typedef struct packed {
    logic [5:0] port_in;
    logic [3:0] kbi_in;
    logic [1:0] tmr1_in;
    logic [1:0] tclk_in;
    logic tmr2_cap_in;
    logic irq_in;
    logic dbg_in;
    logic [3:0] adc_conn;
    logic [3:0] an2_conn;
  } ppc_route_t;

endpackage

// ---- verification/port_pin_function_and_pad_control_tb.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
////////////////////////////////////////////////////////////////////////////////
module port_pin_function_and_pad_control_tb;
  import ppc_pkg::*;

  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, sys_rst_n, bg_mode, dbg_bit_tick, err;
  logic [5:0] pad_in, pur, slr, drr;
  logic [5:0] board_en = 6'h00, board_val = 6'h00;
  logic [63:0] r64;
  ppc_pad_t pad, e;
  ppc_periph_t periph = '0, p;
  ppc_route_t route;
  int miscompares = 0, n_tests = 0, n;

  // Clock at 10 MHz
  initial
    forever #50 core_clk = ~core_clk;

  ppc_pin_ctrl DUT (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
    .pad(pad), .periph(periph), .route(route), .sys_rst_n(sys_rst_n), .bg_mode(bg_mode),
    .dbg_bit_tick(dbg_bit_tick));

  ppc_board board (.core_clk(core_clk), .pad(pad), .board_en(board_en), .board_val(board_val), .pad_in(pad_in));

  ////////////////////////////////////////////////////////////////////////////////
  // One APB transfer; the request stands until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (k >= 20)
      miscompares++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK(rd, x)
  endtask

  // Bounded wait for the internal reset to reach a level
  task automatic wait_sys(input logic lvl);
    int k;
    k = 0;
    while (sys_rst_n !== lvl && k < 40)
    begin
      @(posedge core_clk);
      k++;
    end
    `CHK(sys_rst_n, lvl)
  endtask

  // Power-on reset; the debug pod may hold the mode pin low across release
  task automatic por(input logic mode_lo);
    @(posedge core_clk);
    rst_n <= 1'b0;
    board_en[4] <= mode_lo;
    board_val[4] <= 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    wait_sys(1'b1);
    board_en[4] <= 1'b0;
  endtask

  // Expected pads with debug and reset pin functions off
  function automatic ppc_pad_t model(ppc_periph_t q, logic [5:0] pu_b, logic [5:0] sl_b, logic [5:0] dr_b);
    ppc_pad_t m;
    logic [5:0] an, kb, rise, usr;
    m = '0;
    an = {2'b00, q.adc_en | q.an2_en};
    kb = {q.irq_en, 1'b0, q.kbi_en} & ~an;
    rise = {q.irq_rise, 1'b0, q.kbi_rise};
    m.out = q.port_out;
    m.oe_n = ~(q.port_dir & ~kb & ~an & 6'h1f);
    for (int i = 0; i < 2; i++)
      if (q.tmr1_en[i] && !an[i])
      begin
        kb[i] = 1'b0;
        m.oe_n[i] = ~q.tmr1_oe[i];
        m.out[i] = q.tmr1_out[i];
      end
    if (q.tmr2_oe)
    begin
      m.oe_n[4] = 1'b0;
      m.out[4] = q.tmr2_out;
    end
    m.out = m.out & ~m.oe_n;
    usr = pu_b & m.oe_n & ~an;
    m.pd = usr & kb & rise;
    m.pu = usr & ~m.pd;
    m.slew = sl_b & ~m.oe_n;
    m.drive = dr_b & ~m.oe_n;
    m.analog = an;
    return m;
  endfunction

  task end_of_test;
    if (miscompares == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog, far beyond the few hundred cycles the sequence needs
  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    end_of_test;
  end

  // Main sequence
  initial
  begin
    void'($urandom(44));
    por(1'b0);
    @(negedge core_clk);
    `CHK(bg_mode, 1'b0)
    `CHK({pad.oe_n, pad.pu, pad.pd}, 18'h3f400)
    rchk(8'h00, 32'h2);
    rchk(8'h04, 32'h0);
    rchk(8'h08, 32'h10);
    rchk(8'h0c, 32'h0);
    rchk(8'h10, 32'h00100000);
    rchk(8'h18, 32'h0);
    `CHK(err, 1'b1)
    // Spacing of debug bit ticks while the debug line owns the pin
    n = 0;
    while (dbg_bit_tick !== 1'b1 && n < 40)
    begin
      @(posedge core_clk);
      n++;
    end
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (dbg_bit_tick !== 1'b1 && n < 40);
    `CHK(n, 16)
    apb(1'b1, 8'h00, 32'h0);
    rchk(8'h00, 32'h0);
    // Random pad settings and peripheral requests against the model
    for (int it = 0; it < 24; it++)
    begin
      pur = 6'($urandom());
      slr = 6'($urandom());
      drr = 6'($urandom());
      apb(1'b1, 8'h04, {26'h0, pur});
      apb(1'b1, 8'h08, {26'h0, slr});
      apb(1'b1, 8'h0c, {26'h0, drr});
      rchk(8'h04, {26'h0, pur});
      rchk(8'h08, {26'h0, slr});
      rchk(8'h0c, {26'h0, drr});
      r64 = {$urandom(), $urandom()};
      p = ppc_periph_t'(r64[$bits(ppc_periph_t)-1:0]);
      p.tclk_en = 2'b00;
      p.tmr2_cap_mode = 1'b0;
      p.dbg_oe = 1'b0;
      p.dbg_out = 1'b0;
      periph <= p;
      repeat (2) @(posedge core_clk);
      @(negedge core_clk);
      e = model(p, pur, slr, drr);
      `CHK({pad.oe_n, pad.out}, {e.oe_n, e.out})
      `CHK({pad.pu, pad.pd}, {e.pu, e.pd})
      `CHK({pad.slew, pad.drive}, {e.slew, e.drive})
      `CHK(pad.analog, e.analog)
      `CHK({route.adc_conn, route.an2_conn}, {p.adc_en, p.an2_en})
    end
    // Capture input routed from the shared reset pin
    @(posedge core_clk);
    p = '0;
    p.tmr2_cap_mode = 1'b1;
    periph <= p;
    board_en[5] <= 1'b1;
    for (int v = 0; v < 2; v++)
    begin
      board_val[5] <= v[0];
      repeat (3) @(posedge core_clk);
      `CHK(route.tmr2_cap_in, v[0])
      `CHK({route.port_in[5], route.irq_in, route.dbg_in}, {v[0], 2'b01})
    end
    // The board drives the reset pin from here on, so it never floats low
    board_val[5] <= 1'b1;
    periph <= '0;
    // Reset pin function: set, sticky, pull-up
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h00, 32'h1);
    rchk(8'h00, 32'h1);
    apb(1'b1, 8'h00, 32'h0);
    rchk(8'h00, 32'h1);
    @(negedge core_clk);
    `CHK(pad.pu[5], 1'b1)
    // External source pulls the reset pin low
    @(posedge core_clk);
    board_val[5] <= 1'b0;
    board_en[5] <= 1'b1;
    wait_sys(1'b0);
    board_val[5] <= 1'b1;
    wait_sys(1'b1);
    `CHK(bg_mode, 1'b0)
    rchk(8'h00, 32'h3);
    // Force reset with the mode pin held low
    board_en[4] <= 1'b1;
    board_val[4] <= 1'b0;
    apb(1'b1, 8'h14, 32'h1);
    wait_sys(1'b0);
    @(negedge core_clk);
    `CHK({pad.oe_n[4], pad.pu[4]}, 2'b11)
    wait_sys(1'b1);
    board_en[4] <= 1'b0;
    `CHK(bg_mode, 1'b1)
    // Power-on into background mode defaults the reset pin function on
    por(1'b1);
    `CHK(bg_mode, 1'b1)
    rchk(8'h00, 32'h3);
    end_of_test;
  end
endmodule

// ---- verification/ppc_board.sv ----
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Board side of the six pins: pull resistors, external reset source, debug pod
module ppc_board (
  // Clock
  input wire logic core_clk,
  // Pad controls from the block
  input ppc_pkg::ppc_pad_t pad,
  // Board drive requested by the bench
  input wire logic [5:0] board_en,
  input wire logic [5:0] board_val,
  // Pin levels back to the block
  output logic [5:0] pad_in
);
  import ppc_pkg::*;

  logic flip_r = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // A floating pin must not settle to a tidy value, so it toggles every cycle
  always @(posedge core_clk)
    flip_r <= ~flip_r;

  // Wire level: block drive first, then board drive, then the pull devices
  always_comb
  begin
    for (int i = 0; i < 6; i++)
    begin
      if (!pad.oe_n[i])
        pad_in[i] = pad.out[i];
      else if (board_en[i])
        pad_in[i] = board_val[i];
      else if (pad.pu[i])
        pad_in[i] = 1'b1;
      else if (pad.pd[i])
        pad_in[i] = 1'b0;
      else
        pad_in[i] = flip_r ^ i[0];
    end
  end
endmodule
